// [logic/tkpc_pkg.sv]
/*
  Shared constants and types for the touch key period counter.
  Assumes a 32-bit APB slave with byte addresses in the low 8 bits.
*/
`default_nettype none
package tkpc_pkg;

  localparam int REFCNT_W = 12;
  localparam int TIMER_W  = 16;
  localparam int NKEYS    = 4;
  localparam int NPINS    = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_ANCS   = 8'h08;
  localparam logic [7:0] OFS_T2LO   = 8'h0C;
  localparam logic [7:0] OFS_T2HI   = 8'h10;
  localparam logic [7:0] OFS_REFCNT = 8'h14;
  localparam logic [7:0] OFS_PINS   = 8'h18;

  // Field positions in the pin and counter status words
  localparam int PINS_OUT_LSB = 0;
  localparam int PINS_OE_LSB  = 8;
  localparam int PINS_IN_LSB  = 16;
  localparam int REFCNT_BUSY  = 16;

  // Reference period masks: period minus one
  localparam logic [11:0] MASK_512  = 12'h1FF;
  localparam logic [11:0] MASK_1024 = 12'h3FF;
  localparam logic [11:0] MASK_2048 = 12'h7FF;
  localparam logic [11:0] MASK_4096 = 12'hFFF;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic reference_osc_enable;
    logic sensor_osc_enable;
    logic refcnt_clear_bit;
    logic period_sel_hi;
    logic period_sel_lo;
    logic rsvd;
    logic key_select_hi;
    logic key_select_lo;
  } tkpc_ctrl0_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       irq_enable;
    logic       refkey_pin_select;
    logic       refcnt_overflow_flag;
    logic       measure_start_bit;
  } tkpc_ctrl1_t;

  localparam tkpc_ctrl0_t CTRL0_RST = 8'h00;
  localparam tkpc_ctrl1_t CTRL1_RST = 8'h00;
  localparam logic [3:0]  ANCS_RST  = 4'h0;
  localparam logic [4:0]  PIN_RST   = 5'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } tkpc_state_t;

endpackage
`default_nettype wire

// [logic/tkpc_sync_edge.sv]
/*
  Two-flop synchroniser with rising-edge detect for W pin inputs.
  Assumes the inputs are asynchronous to pclk and slower than pclk/2.
*/
`timescale 1ns/1ps
`default_nettype none
module tkpc_sync_edge
  import tkpc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,     // System clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic         ce,       // Clock enable
  input  wire logic [W-1:0] async_in, // Pin level
  output logic      [W-1:0] sync_out, // Synchronised level
  output logic      [W-1:0] rise_out  // One-cycle rising pulse
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;
  logic [W-1:0] next_prev;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else if (ce) begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Only the second and third stages feed logic
  assign sync_out = sync;
  assign rise_out = sync & ~prev;

endmodule
`default_nettype wire

// [logic/tkpc_top.sv]
/*
  Touch key period counter with APB register access.
  Reference and sensor oscillator clocks arrive as pins and are
  sampled on pclk; both must run well below half of pclk.
  // Function
  // (RULE1) Twelve-bit reference counter advances on synced reference clock.
  // (RULE2) Two-bit period select chooses 512 to 4096 reference cycles.
  // (RULE3) Codes 00,01,10,11 give 512,1024,2048,4096 cycles.
  // (RULE4) Reaching the period stops the counter and raises the request.
  // (RULE5) Start bit rising starts the reference counter.
  // (RULE6) Start bit rising during a measurement changes nothing.
  // (RULE7) Clear bit rising zeroes the counter; software clears first.
  // (RULE8) While counting, gated sensor edges advance timer two.
  // (RULE9) Sensor gate closes in the cycle the request rises.
  // (RULE10) Timer two then stops and holds its count for reading.
  // (RULE11) Period end sets the overflow flag and signals interrupt.
  // (RULE12) Overflow flag is read-only, cleared when start bit rises.
  // (RULE13) Interrupt controller vectors only if enabled, stack not full.
  // (RULE14) With interrupt disabled the event is only a wake-up.
  // (RULE15) Each key pin is I/O or touch input by its own bit.
  // (RULE16) Reference pin select bit picks I/O or reference key use.
  // (RULE17) Key select connects one key to the oscillator, others ground.
  // (RULE18) Software enables oscillators and pins before a measurement.
  // (RULE19) Software scans keys and compares counts with baselines.
  // (RULE20) After a period everything stays stopped until next start.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tkpc_top
  import tkpc_pkg::*;
(
  input  wire logic             pclk,          // System clock
  input  wire logic             presetn,       // Async reset, active low
  input  wire logic             ce,            // Clock enable
  input  wire logic             psel,          // APB select
  input  wire logic             penable,       // APB enable
  input  wire logic             pwrite,        // APB write
  input  wire logic [7:0]       paddr,         // APB byte address
  input  wire logic [31:0]      pwdata,        // APB write data
  output logic      [31:0]      prdata,        // APB read data
  output logic                  pready,        // APB ready
  output logic                  pslverr,       // APB error
  input  wire logic             reference_osc_clock, // Ref osc pin
  input  wire logic             sensor_osc_clock,    // Sensor osc pin
  input  wire logic [NKEYS-1:0] touch_key_pins_i,    // Key pin levels
  output logic      [NKEYS-1:0] touch_key_pins_o,    // Key pin drive
  output logic      [NKEYS-1:0] touch_key_pins_oe,   // Key pin enable
  input  wire logic             reference_key_pin_i, // Ref pin level
  output logic                  reference_key_pin_o, // Ref pin drive
  output logic                  reference_key_pin_oe,// Ref pin enable
  output logic      [NKEYS-1:0] key_switch_osc,      // Key to oscillator
  output logic      [NKEYS-1:0] key_switch_gnd,      // Key to ground
  output logic                  refkey_switch,       // Ref key switch
  output logic                  reference_osc_enable,// Ref osc enable
  output logic                  sensor_osc_enable,   // Sensor osc enable
  output logic                  gated_sensor_clock,  // Gated sensor pulse
  output logic                  measure_busy,        // Period running
  output logic                  touch_irq,           // Interrupt pulse
  output logic                  touch_wake           // Wake-up pulse
);

  function automatic logic [REFCNT_W-1:0] period_mask(
    input logic hi,
    input logic lo
  );
    logic [REFCNT_W-1:0] m;
    unique case ({hi, lo})
      2'b00: m = MASK_512;
      2'b01: m = MASK_1024;
      2'b10: m = MASK_2048;
      2'b11: m = MASK_4096;
    endcase
    return m;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_ANCS) ||
           (a == OFS_T2LO) || (a == OFS_T2HI) || (a == OFS_REFCNT) ||
           (a == OFS_PINS);
  endfunction

  logic [1:0]       osc_rise;
  logic [NPINS-1:0] pin_sync;
  logic             ref_rise;
  logic             sen_rise;

  tkpc_sync_edge #(.W(2)) u_osc_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({sensor_osc_clock, reference_osc_clock}),
    .sync_out (),
    .rise_out (osc_rise)
  );

  tkpc_sync_edge #(.W(NPINS)) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({reference_key_pin_i, touch_key_pins_i}),
    .sync_out (pin_sync),
    .rise_out ()
  );

  assign ref_rise = osc_rise[0];
  assign sen_rise = osc_rise[1];

  tkpc_ctrl0_t         ctrl0;
  tkpc_ctrl1_t         ctrl1;
  logic [3:0]          ancs;
  logic [NPINS-1:0]    pin_out;
  logic [NPINS-1:0]    pin_oe;
  logic [REFCNT_W-1:0] refcnt;
  logic [TIMER_W-1:0]  timer;
  tkpc_state_t         state;
  logic                irq;
  logic                wake;
  logic                gclk;
  logic                rd_ready;
  logic [31:0]         rdata;
  logic                rerr;
  logic [NKEYS-1:0]    sw_osc;
  logic [NKEYS-1:0]    sw_gnd;

  tkpc_ctrl0_t         next_ctrl0;
  tkpc_ctrl1_t         next_ctrl1;
  logic [3:0]          next_ancs;
  logic [NPINS-1:0]    next_pin_out;
  logic [NPINS-1:0]    next_pin_oe;
  logic [REFCNT_W-1:0] next_refcnt;
  logic [TIMER_W-1:0]  next_timer;
  tkpc_state_t         next_state;
  logic                next_irq;
  logic                next_wake;
  logic                next_gclk;
  logic                next_rd_ready;
  logic [31:0]         next_rdata;
  logic                next_rerr;
  logic [NKEYS-1:0]    next_sw_osc;
  logic [NKEYS-1:0]    next_sw_gnd;

  logic                wr;
  logic                start_rise;
  logic                clear_rise;
  logic                period_end;
  logic [REFCNT_W-1:0] mask;
  tkpc_ctrl0_t         w0;
  tkpc_ctrl1_t         w1;
  logic [NKEYS-1:0]    key_dec;

  assign mask = period_mask(ctrl0.period_sel_hi, ctrl0.period_sel_lo); // RULE3
  assign w0   = tkpc_ctrl0_t'(pwdata[7:0]);
  assign w1   = tkpc_ctrl1_t'(pwdata[7:0]);
  assign wr   = psel && penable && pwrite && rd_ready;
  assign start_rise = wr && (paddr == OFS_CTRL1) &&
                      w1.measure_start_bit && !ctrl1.measure_start_bit;
  assign clear_rise = wr && (paddr == OFS_CTRL0) &&
                      w0.refcnt_clear_bit && !ctrl0.refcnt_clear_bit;
  // Only the selected low counter bits are compared, so every period restarts
  assign period_end = (state == ST_RUN) && ref_rise &&
                      ((refcnt & mask) == mask); // RULE2

  // One key decoded per pin; unselected touch pins go to ground
  genvar gi;
  generate
    for (gi = 0; gi < NKEYS; gi++) begin : g_key
      assign key_dec[gi] =
        ({ctrl0.key_select_hi, ctrl0.key_select_lo} == 2'(gi));
      assign next_sw_osc[gi] = ancs[gi] && key_dec[gi]; // RULE17 RULE15
      assign next_sw_gnd[gi] = ancs[gi] && !key_dec[gi]; // RULE17
    end
  endgenerate

  always_comb begin
    next_ctrl0    = ctrl0;
    next_ctrl1    = ctrl1;
    next_ancs     = ancs;
    next_pin_out  = pin_out;
    next_pin_oe   = pin_oe;
    next_refcnt   = refcnt;
    next_timer    = timer;
    next_state    = state;
    next_irq      = 1'b0;
    next_wake     = 1'b0;
    next_gclk     = 1'b0;
    next_rd_ready = psel && !(penable && rd_ready);
    next_rdata    = rdata;
    next_rerr     = rerr;

    // Snapshot read data before ready, so prdata comes from a flop
    if (psel && !rd_ready) begin
      next_rerr  = !reg_hit(paddr);
      next_rdata = RD_ZERO;
      unique case (paddr)
        OFS_CTRL0:  next_rdata[7:0] = ctrl0;
        OFS_CTRL1:  next_rdata[7:0] = ctrl1;
        OFS_ANCS:   next_rdata[3:0] = ancs;
        OFS_T2LO:   next_rdata[7:0] = timer[7:0]; // RULE10
        OFS_T2HI:   next_rdata[7:0] = timer[15:8];
        OFS_REFCNT: begin
          next_rdata[REFCNT_W-1:0] = refcnt;
          next_rdata[REFCNT_BUSY]  = (state == ST_RUN);
        end
        OFS_PINS: begin
          next_rdata[PINS_OUT_LSB +: NPINS] = pin_out;
          next_rdata[PINS_OE_LSB +: NPINS]  = pin_oe;
          next_rdata[PINS_IN_LSB +: NPINS]  = pin_sync;
        end
        default: next_rdata = RD_ZERO;
      endcase
    end

    if (wr) begin
      unique case (paddr)
        OFS_CTRL0: begin
          next_ctrl0      = w0;
          next_ctrl0.rsvd = 1'b0;
        end
        OFS_CTRL1: begin
          next_ctrl1.measure_start_bit = w1.measure_start_bit;
          next_ctrl1.refkey_pin_select = w1.refkey_pin_select;
          next_ctrl1.irq_enable        = w1.irq_enable;
        end
        OFS_ANCS: next_ancs = pwdata[3:0];
        OFS_PINS: begin
          next_pin_out = pwdata[PINS_OUT_LSB +: NPINS];
          next_pin_oe  = pwdata[PINS_OE_LSB +: NPINS];
        end
        default: ;
      endcase
    end

    unique case (state)
      ST_IDLE, ST_DONE: begin
        // Start while counting falls through to the run branch unseen
        if (start_rise) begin
          next_state = ST_RUN; // RULE5 RULE20
          next_ctrl1.refcnt_overflow_flag = 1'b0; // RULE12
          next_timer = '0;
        end
      end
      ST_RUN: begin // RULE6
        if (ref_rise) begin
          next_refcnt = refcnt + 1'b1; // RULE1
        end
        if (sen_rise) begin
          next_timer = timer + 1'b1; // RULE8
          next_gclk  = 1'b1;
        end
        if (period_end) begin
          next_state = ST_DONE; // RULE4 RULE9
          next_ctrl1.refcnt_overflow_flag = 1'b1; // RULE11
          next_wake  = 1'b1; // RULE14
          next_irq   = ctrl1.irq_enable; // RULE14
        end
      end
      default: next_state = ST_IDLE;
    endcase

    if (clear_rise) begin
      next_refcnt = '0; // RULE7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0    <= CTRL0_RST;
      ctrl1    <= CTRL1_RST;
      ancs     <= ANCS_RST;
      pin_out  <= PIN_RST;
      pin_oe   <= PIN_RST;
      refcnt   <= '0;
      timer    <= '0;
      state    <= ST_IDLE;
      irq      <= 1'b0;
      wake     <= 1'b0;
      gclk     <= 1'b0;
      rd_ready <= 1'b0;
      rdata    <= RD_ZERO;
      rerr     <= 1'b0;
      sw_osc   <= '0;
      sw_gnd   <= '0;
    end else if (ce) begin
      ctrl0    <= next_ctrl0;
      ctrl1    <= next_ctrl1;
      ancs     <= next_ancs;
      pin_out  <= next_pin_out;
      pin_oe   <= next_pin_oe;
      refcnt   <= next_refcnt;
      timer    <= next_timer;
      state    <= next_state;
      irq      <= next_irq;
      wake     <= next_wake;
      gclk     <= next_gclk;
      rd_ready <= next_rd_ready;
      rdata    <= next_rdata;
      rerr     <= next_rerr;
      sw_osc   <= next_sw_osc;
      sw_gnd   <= next_sw_gnd;
    end
  end

  assign pready  = rd_ready && ce;
  assign prdata  = rdata;
  assign pslverr = rerr;

  // Touch inputs lose their I/O drivers
  assign touch_key_pins_o  = pin_out[NKEYS-1:0] & ~ancs; // RULE15
  assign touch_key_pins_oe = pin_oe[NKEYS-1:0] & ~ancs; // RULE15
  assign reference_key_pin_o =
    pin_out[NKEYS] && !ctrl1.refkey_pin_select; // RULE16
  assign reference_key_pin_oe =
    pin_oe[NKEYS] && !ctrl1.refkey_pin_select; // RULE16
  assign refkey_switch        = ctrl1.refkey_pin_select; // RULE16
  assign key_switch_osc       = sw_osc;
  assign key_switch_gnd       = sw_gnd;
  assign reference_osc_enable = ctrl0.reference_osc_enable;
  assign sensor_osc_enable    = ctrl0.sensor_osc_enable;
  assign gated_sensor_clock   = gclk;
  assign measure_busy         = (state == ST_RUN);
  assign touch_irq            = irq;
  assign touch_wake           = wake;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DONE_ON_PERIOD: assert property ( // RULE4
    ce && period_end |=> state == ST_DONE && touch_wake && !measure_busy
  ) else $error("period end did not stop the measurement");

  AST_NO_EARLY_END: assert property ( // RULE2
    ce && state == ST_RUN && (refcnt & mask) != mask |=> state == ST_RUN
  ) else $error("measurement ended before the selected period");

  AST_START_RUNS: assert property ( // RULE5
    ce && start_rise && state != ST_RUN
    |=> state == ST_RUN && !ctrl1.refcnt_overflow_flag && timer == '0
  ) else $error("start did not begin a measurement");

  AST_RETRIGGER_IGNORED: assert property ( // RULE6
    ce && start_rise && state == ST_RUN && !period_end
    |=> state == ST_RUN && ctrl1.refcnt_overflow_flag == $past(
      ctrl1.refcnt_overflow_flag)
  ) else $error("restart disturbed a running measurement");

  AST_CLEAR: assert property ( // RULE7
    ce && clear_rise |=> refcnt == '0
  ) else $error("counter clear ignored");

  AST_TIMER_COUNTS: assert property ( // RULE8
    ce && state == ST_RUN && sen_rise
    |=> timer == TIMER_W'($past(timer) + 1'b1) && gated_sensor_clock
  ) else $error("sensor edge not counted while running");

  AST_GATE_BLOCK: assert property ( // RULE9
    touch_wake |-> !measure_busy ##1 !gated_sensor_clock
  ) else $error("sensor clock not blocked at period end");

  AST_TIMER_FROZEN: assert property ( // RULE10
    state != ST_RUN && !start_rise |=> timer == $past(timer)
  ) else $error("timer moved outside a measurement");

  AST_FLAG_SET: assert property ( // RULE11
    ce && period_end |=> ctrl1.refcnt_overflow_flag
      ##1 (ctrl1.refcnt_overflow_flag || $past(ce && start_rise))
  ) else $error("overflow flag not set at period end");

  AST_FLAG_READONLY: assert property ( // RULE12
    ce && wr && paddr == OFS_CTRL1 && state != ST_RUN && !start_rise
    |=> ctrl1.refcnt_overflow_flag == $past(ctrl1.refcnt_overflow_flag)
  ) else $error("software changed the overflow flag");

  AST_IRQ_GATED: assert property ( // RULE14
    touch_irq |-> touch_wake && $past(ctrl1.irq_enable)
  ) else $error("interrupt raised while disabled");

  AST_KEY_SWITCH: assert property ( // RULE17
    $onehot0(key_switch_osc) && (key_switch_osc & key_switch_gnd) == '0
  ) else $error("more than one key on the oscillator");

  AST_STAY_STOPPED: assert property ( // RULE20
    state == ST_DONE && !start_rise |=> state == ST_DONE
  ) else $error("measurement resumed without start");

endmodule
`default_nettype wire

// [sim/tkpc_osc_model.sv]
/*
  Behavioural reference and sensor oscillators seen at the pins.
  Assumes both half periods are at least two pclk periods.
*/
`timescale 1ns/1ps
`default_nettype none
module tkpc_osc_model #(
  parameter int REF_HALF = 20, // Reference half period in ns
  parameter int SEN_HALF = 30  // Sensor half period in ns
) (
  input  wire logic reference_osc_enable, // Reference osc on
  input  wire logic sensor_osc_enable,    // Sensor osc on
  output var logic  reference_osc_clock,  // Reference osc pin
  output var logic  sensor_osc_clock      // Sensor osc pin
);
  // A disabled oscillator rests low rather than freezing mid-cycle
  always begin
    reference_osc_clock = 1'b0;
    wait (reference_osc_enable === 1'b1);
    while (reference_osc_enable === 1'b1) begin
      #REF_HALF reference_osc_clock = ~reference_osc_clock;
    end
  end
  always begin
    sensor_osc_clock = 1'b0;
    wait (sensor_osc_enable === 1'b1);
    while (sensor_osc_enable === 1'b1) begin
      #SEN_HALF sensor_osc_clock = ~sensor_osc_clock;
    end
  end
endmodule
`default_nettype wire

// [sim/touch_key_period_counter_bench.sv]
/*
  Self-checking bench for the touch key period counter.
  Assumes the oscillator model on the pins and an APB master here.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_key_period_counter_bench
  import tkpc_pkg::*;
;
  typedef struct {
    logic [1:0] sel;
    logic       irq_en;
    int         period;
  } tkpc_row_t;
  localparam int RH = 20;
  localparam int SH = 30;
  logic             pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             pready, pslverr, err, ref_clk, sen_clk;
  logic [NKEYS-1:0] key_i, key_o, key_oe, sw_osc, sw_gnd, ext_keys;
  logic             ref_i, ref_o, ref_oe, ref_sw, ext_ref;
  logic             ref_en, sen_en, gated, busy, irq, wake;
  logic [15:0]      cnt;
  int               compares, miscompares;
  tkpc_row_t        rows [4];

  assign key_i = (key_oe & key_o) | (~key_oe & ext_keys);
  assign ref_i = ref_oe ? ref_o : ext_ref;

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  tkpc_top u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_osc_clock(ref_clk), .sensor_osc_clock(sen_clk),
    .touch_key_pins_i(key_i), .touch_key_pins_o(key_o),
    .touch_key_pins_oe(key_oe), .reference_key_pin_i(ref_i),
    .reference_key_pin_o(ref_o), .reference_key_pin_oe(ref_oe),
    .key_switch_osc(sw_osc), .key_switch_gnd(sw_gnd),
    .refkey_switch(ref_sw), .reference_osc_enable(ref_en),
    .sensor_osc_enable(sen_en), .gated_sensor_clock(gated),
    .measure_busy(busy), .touch_irq(irq), .touch_wake(wake));

  tkpc_osc_model #(.REF_HALF(RH), .SEN_HALF(SH)) u_osc (
    .reference_osc_enable(ref_en), .sensor_osc_enable(sen_en),
    .reference_osc_clock(ref_clk), .sensor_osc_clock(sen_clk));

  task end_of_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task chk_near(input logic [15:0] g, input int e);
    compares++;
    if ($isunknown(g) || int'(g) < e - 3 || int'(g) > e + 3) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic measure(input tkpc_row_t row, input logic [1:0] key,
                         input bit retrig);
    logic [7:0]  c0, c1;
    logic [31:0] lo;
    int          n, g;
    c0 = 8'hC0 | {3'b000, row.sel, 3'b000} | {6'b00_0000, key};
    c1 = {4'h0, row.irq_en, 3'b000};
    apb(1'b1, OFS_CTRL0, {24'h00_0000, c0 | 8'h20});
    apb(1'b1, OFS_CTRL0, {24'h00_0000, c0});
    apb(1'b1, OFS_CTRL1, {24'h00_0000, c1});
    apb(1'b1, OFS_CTRL1, {24'h00_0000, c1 | 8'h01});
    if (retrig) begin
      repeat (200) @(posedge pclk);
      apb(1'b1, OFS_CTRL1, {24'h00_0000, c1});
      apb(1'b0, OFS_CTRL1, 32'h0000_0000);
      chk(rd, {24'h00_0000, c1});
      apb(1'b1, OFS_CTRL1, {24'h00_0000, c1 | 8'h01});
    end
    n = 0;
    while (wake !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 20000) begin
        miscompares++;
        end_of_test;
      end
    end
    chk(32'(irq), 32'(row.irq_en));
    chk(32'(busy), 32'h0000_0000);
    g = 0;
    repeat (64) begin
      @(posedge pclk);
      if (gated !== 1'b0 || busy !== 1'b0) g++;
    end
    chk(32'(g), 32'h0000_0000);
    apb(1'b0, OFS_T2LO, 32'h0000_0000);
    lo = rd;
    apb(1'b0, OFS_T2HI, 32'h0000_0000);
    cnt = {rd[7:0], lo[7:0]};
    repeat (100) @(posedge pclk);
    apb(1'b0, OFS_T2LO, 32'h0000_0000);
    chk(rd, lo);
    apb(1'b0, OFS_CTRL1, 32'h0000_0000);
    chk(rd, {24'h00_0000, c1 | 8'h03});
    apb(1'b0, OFS_REFCNT, 32'h0000_0000);
    chk(32'(rd[REFCNT_BUSY]), 32'h0000_0000);
  endtask

  initial begin
    compares = 0; miscompares = 0; presetn = 1'b0; ce = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; ext_keys = 4'h1; ext_ref = 1'b0;
    rows = '{'{2'b00, 1'b1, 512}, '{2'b01, 1'b0, 1024},
             '{2'b10, 1'b1, 2048}, '{2'b11, 1'b0, 4096}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({ref_en, sen_en, busy, irq, wake, sw_osc, sw_gnd, key_oe}),
        32'h0000_0000);
    apb(1'b0, OFS_CTRL0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, OFS_CTRL1, 32'h0000_0002);
    apb(1'b0, OFS_CTRL1, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, OFS_T2LO, 32'h0000_00FF);
    apb(1'b0, OFS_T2LO, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("test reset done");
    apb(1'b1, OFS_ANCS, 32'h0000_000F);
    for (int k = 0; k < NKEYS; k++) begin
      apb(1'b1, OFS_CTRL0, 32'(k));
      settle;
      chk(32'({sw_osc, sw_gnd}), 32'({4'(1 << k), ~4'(1 << k)}));
    end
    apb(1'b1, OFS_ANCS, 32'h0000_0005);
    apb(1'b1, OFS_PINS, 32'h0000_1F1F);
    settle;
    chk(32'({key_oe, key_o, ref_oe, ref_o}), 32'h0000_02AB);
    apb(1'b0, OFS_PINS, 32'h0000_0000);
    chk(rd, 32'h001B_1F1F);
    apb(1'b1, OFS_CTRL1, 32'h0000_0004);
    settle;
    chk(32'({ref_oe, ref_sw}), 32'h0000_0001);
    apb(1'b0, OFS_PINS, 32'h0000_0000);
    chk(rd, 32'h000B_1F1F);
    apb(1'b1, OFS_CTRL1, 32'h0000_0000);
    apb(1'b1, OFS_ANCS, 32'h0000_000F);
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      measure(rows[i], i[1:0], 1'b0);
      chk_near(cnt, rows[i].period * 2 * RH / (2 * SH));
      $display("test period row %0d done", i);
    end
    // Retrigger mid-run must neither restart nor stretch the period
    measure(rows[0], 2'd3, 1'b1);
    chk_near(cnt, rows[0].period * RH / SH);
    $display("test retrigger done");
    end_of_test;
  end
endmodule
`default_nettype wire
